//--- cpu_core_regs_pc_stack.v
`timescale 1ns/1ps
`include "cpu_core_defines.vh"
// Contract
// - Two 128K program banks, 64K data, 16M external.
// - Program counter is 17 bits plus bank flag.
// - Ordinary step adds byte count, bank kept.
// - Reset or interrupt loads vector, bank cleared.
// - Taken branch adds count plus signed displacement.
// - Only returns popping the stack load the bank; reset and interrupt clear it.
// - Call writes bank/low at SP+1, high SP+2.
// - RAM below FE00 is nine bits wide.
// - Low 128 bytes pair into 64 indirect registers.
// - Operand-high joins working register for 16-bit results.
// - Operand-high supplies far address bits 23..16.
// - Offset register is signed, added to indirect.
// - Working, operand-high, offset, status clear on reset.
// - Carry flag follows carry, borrow, rotation carry.
// - Half-carry flag follows carry out of bit 3.
// - Status bits 5 and 4 are user flags.
// - Status bit 3 selects table read bank; the code takes the bank from the ninth bit of the odd indirect byte instead.
// - Range flag follows overflow, multiply, zero divisor.
// - Status bit 0 shows working register parity.
// - Stack pointer 16 bits, split, reset zero.
// - Save increments pointer, then writes RAM.
// - Restore reads RAM, then decrements pointer.
// - Return pops high, then bank with low.
module cpu_core_regs_pc_stack
(
   input  wire        i_clk,          // CPU clock.
   input  wire        i_sys_rst,      // Synchronous active-high reset.
   // Program counter control.
   input  wire [2:0]  i_pc_op,        // Program counter operation code.
   input  wire [2:0]  i_inst_bytes,   // Byte count of the current instruction.
   input  wire        i_branch_taken, // Conditional branch condition is true.
   input  wire [7:0]  i_branch_disp,  // Signed 8-bit branch displacement.
   input  wire [16:0] i_jump_target,  // Absolute target for jumps and calls.
   input  wire [3:0]  i_intr_index,   // Interrupt vector index 0 to 9.
   // Data-space access from the execution unit.
   input  wire        i_mem_wr,       // Write strobe into the data space.
   input  wire        i_mem_rd,       // Read strobe from the data space.
   input  wire [15:0] i_mem_addr,     // Data-space byte address.
   input  wire [7:0]  i_mem_wdata,    // Write data.
   input  wire        i_push,         // Push one byte onto the stack.
   input  wire        i_pop,          // Pop one byte from the stack.
   // Arithmetic result updates.
   input  wire        i_alu_wr,       // Load working register with arithmetic result.
   input  wire [7:0]  i_alu_result,   // New working register value.
   input  wire        i_alu_wr_high,  // Load operand-high with high result.
   input  wire [7:0]  i_alu_high,     // High result byte.
   input  wire        i_alu_wr_ext,   // Load offset register with extended result.
   input  wire [7:0]  i_alu_ext,      // Extended result byte.
   input  wire        i_carry_en,     // Update the carry flag.
   input  wire        i_carry_in,     // New carry flag value.
   input  wire        i_half_en,      // Update the half-carry flag.
   input  wire        i_half_in,      // New half-carry flag value.
   input  wire        i_range_en,     // Update the range flag.
   input  wire        i_range_in,     // New range flag value.
   // Indirect addressing request.
   input  wire [5:0]  i_ind_sel,      // Indirect register number.
   input  wire        i_ind_use_off,  // Add the signed offset register.
   input  wire [15:0] i_far_low,      // Low 16 bits of a far address.
   // Outputs.
   output reg  [16:0] o_program_counter, // Current program counter.
   output reg         o_rom_bank_flag,   // Current program bank.
   output reg  [7:0]  o_mem_rdata,       // Data-space read data.
   output reg  [15:0] o_ind_addr,        // Resolved indirect address.
   output reg  [16:0] o_table_addr,      // 17-bit table read address.
   output reg  [23:0] o_far_addr,        // 24-bit external address.
   output reg  [15:0] o_arith_word,      // 16-bit pair of high and working.
   output reg  [15:0] o_stack_pointer,   // Current stack pointer.
   output reg  [7:0]  o_status_word      // Current status word.
);

   // ======================================================================
   // Storage.
   reg  [8:0]  ram_mem [0:`RAM_DEPTH-1];  // Nine-bit RAM below the SFR area.
   reg  [16:0] pc_reg;                    // Program counter.
   reg  [16:0] pc_next;                   // Next program counter.
   reg         bank_reg;                  // Program bank flag.
   reg         bank_next;                 // Next bank flag.
   reg  [7:0]  working_reg;               // Working register.
   reg  [7:0]  ophigh_reg;                // Operand-high register.
   reg  [7:0]  offset_reg;                // Offset register.
   reg  [7:0]  psw_reg;                   // Status word, parity bit unused.
   reg  [15:0] sp_reg;                    // Stack pointer.
   reg  [1:0]  call_phase_reg;            // Call frame write step.
   reg  [1:0]  ret_phase_reg;             // Return frame read step.
   reg  [8:0]  ret_high_reg;              // High nine PC bits between frame steps.
   wire        parity_w;                  // Live working register parity.

   // Parity is recomputed continuously, so the flag can never go stale.
   assign parity_w = ^working_reg;

   // ======================================================================
   // Helpers.
   // True when an address falls in the nine-bit RAM.
   function in_ram;
      input [15:0] a;
      begin
         in_ram = (a <= `RAM_TOP);
      end
   endfunction

   // Sign-extends an 8-bit value to 17 bits.
   function [16:0] sext8;
      input [7:0] v;
      begin
         sext8 = {{9{v[7]}}, v};
      end
   endfunction

   // ======================================================================
   // Program counter next value.
   // Only the return path writes the bank flag; every other load keeps it,
   // except reset and interrupt entry, which force bank zero.
   always @*
   begin
      pc_next   = pc_reg;
      bank_next = bank_reg;
      case (i_pc_op)
         `PC_OP_STEP:
         begin
            pc_next = pc_reg + {14'h0000, i_inst_bytes};
         end
         `PC_OP_BRANCH:
         begin
            // Not-taken branches still step past the instruction.
            if (i_branch_taken)
            begin
               pc_next = pc_reg + {14'h0000, i_inst_bytes} + sext8(i_branch_disp);
            end
            else
            begin
               pc_next = pc_reg + {14'h0000, i_inst_bytes};
            end
         end
         `PC_OP_JUMP, `PC_OP_CALL:
         begin
            pc_next = i_jump_target;
         end
         `PC_OP_INTR:
         begin
            // Vectors sit eight bytes apart; indices past the last clamp.
            if (i_intr_index <= `VEC_LAST)
            begin
               pc_next = `VEC_BASE + {10'h000, i_intr_index, 3'h0};
            end
            else
            begin
               pc_next = `VEC_BASE + {10'h000, `VEC_LAST, 3'h0};
            end
            bank_next = 1'b0;
         end
         default:
         begin
            pc_next   = pc_reg;
            bank_next = bank_reg;
         end
      endcase
   end

   // ======================================================================
   // Program counter, stack and frame sequencing.
   // A call writes its low frame entry at once and the high one a cycle later.
   // A return takes two cycles of reads before the new PC appears.
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pc_reg         <= `RST_PC;
         bank_reg       <= 1'b0;
         sp_reg         <= 16'h0000;
         call_phase_reg <= 2'h0;
         ret_phase_reg  <= 2'h0;
         ret_high_reg   <= 9'h000;
      end
      else if (call_phase_reg == 2'h1)
      begin
         // High nine bits of the saved counter land at the original SP+2.
         ram_mem[sp_reg + 16'h0001] <= ret_high_reg;
         sp_reg                     <= sp_reg + 16'h0001;
         call_phase_reg             <= 2'h0;
      end
      else if (ret_phase_reg == 2'h1)
      begin
         // First pop is the high nine bits.
         ret_high_reg  <= ram_mem[sp_reg];
         sp_reg        <= sp_reg - 16'h0001;
         ret_phase_reg <= 2'h2;
      end
      else if (ret_phase_reg == 2'h2)
      begin
         // Second pop carries the bank flag in its ninth bit.
         pc_reg        <= {ret_high_reg, ram_mem[sp_reg][7:0]};
         bank_reg      <= ram_mem[sp_reg][8];
         sp_reg        <= sp_reg - 16'h0001;
         ret_phase_reg <= 2'h0;
      end
      else if (i_pc_op == `PC_OP_RETURN)
      begin
         ret_phase_reg <= 2'h1;
      end
      else
      begin
         pc_reg   <= pc_next;
         bank_reg <= bank_next;
         // Call and interrupt entry save the counter held when the request is taken.
         if ((i_pc_op == `PC_OP_CALL) || (i_pc_op == `PC_OP_INTR))
         begin
            // The counter is still the pre-load value here, so that is what is saved.
            ram_mem[sp_reg + 16'h0001] <= {bank_reg, pc_reg[7:0]};
            sp_reg                     <= sp_reg + 16'h0001;
            ret_high_reg               <= pc_reg[16:8];
            call_phase_reg             <= 2'h1;
         end
         else if (i_push)
         begin
            ram_mem[sp_reg + 16'h0001] <= {psw_reg[`PSW_NINTH], i_mem_wdata};
            sp_reg                     <= sp_reg + 16'h0001;
         end
         else if (i_pop)
         begin
            sp_reg <= sp_reg - 16'h0001;
         end
         else if (i_mem_wr && (i_mem_addr == `ADDR_SP_LOW))
         begin
            sp_reg[7:0] <= i_mem_wdata;
         end
         else if (i_mem_wr && (i_mem_addr == `ADDR_SP_HIGH))
         begin
            sp_reg[15:8] <= i_mem_wdata;
         end
         else if (i_mem_wr && in_ram(i_mem_addr))
         begin
            ram_mem[i_mem_addr] <= {psw_reg[`PSW_NINTH], i_mem_wdata};
         end
      end
   end

   // ======================================================================
   // Working, operand-high, offset and status registers.
   // Arithmetic updates win over software writes in the same cycle.
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         working_reg <= `RST_BYTE;
         ophigh_reg  <= `RST_BYTE;
         offset_reg  <= `RST_BYTE;
         psw_reg     <= `RST_BYTE;
      end
      else
      begin
         if (i_alu_wr)
         begin
            working_reg <= i_alu_result;
         end
         else if (i_mem_wr && (i_mem_addr == `ADDR_WORKING))
         begin
            working_reg <= i_mem_wdata;
         end
         if (i_alu_wr_high)
         begin
            ophigh_reg <= i_alu_high;
         end
         else if (i_mem_wr && (i_mem_addr == `ADDR_OPHIGH))
         begin
            ophigh_reg <= i_mem_wdata;
         end
         if (i_alu_wr_ext)
         begin
            offset_reg <= i_alu_ext;
         end
         else if (i_mem_wr && (i_mem_addr == `ADDR_OFFSET))
         begin
            offset_reg <= i_mem_wdata;
         end
         // Software write first, then hardware flag updates override it.
         if (i_mem_wr && (i_mem_addr == `ADDR_PSW))
         begin
            psw_reg <= {i_mem_wdata[7:1], 1'b0};
         end
         else if (i_pop)
         begin
            // A pop reloads the ninth-bit flag from the popped byte.
            psw_reg[`PSW_NINTH] <= ram_mem[sp_reg][8];
         end
         else if (i_mem_rd && in_ram(i_mem_addr))
         begin
            psw_reg[`PSW_NINTH] <= ram_mem[i_mem_addr][8];
         end
         if (i_carry_en)
         begin
            psw_reg[`PSW_CARRY] <= i_carry_in;
         end
         if (i_half_en)
         begin
            psw_reg[`PSW_HALF] <= i_half_in;
         end
         if (i_range_en)
         begin
            psw_reg[`PSW_RANGE] <= i_range_in;
         end
      end
   end

   // ======================================================================
   // Output registers.
   // Every output is a flop; reads and derived addresses lag one cycle.
   always @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_program_counter <= 17'h00000;
         o_rom_bank_flag   <= 1'b0;
         o_mem_rdata       <= 8'h00;
         o_ind_addr        <= 16'h0000;
         o_table_addr      <= 17'h00000;
         o_far_addr        <= 24'h000000;
         o_arith_word      <= 16'h0000;
         o_stack_pointer   <= 16'h0000;
         o_status_word     <= 8'h00;
      end
      else
      begin
         o_program_counter <= pc_reg;
         o_rom_bank_flag   <= bank_reg;
         o_stack_pointer   <= sp_reg;
         o_status_word     <= {psw_reg[7:1], parity_w};
         o_arith_word      <= {ophigh_reg, working_reg};
         o_far_addr        <= {ophigh_reg, i_far_low};
         // Indirect register pair: low byte even, high byte odd.
         if (i_ind_use_off)
         begin
            o_ind_addr <= {ram_mem[{9'h000, i_ind_sel, 1'b1}][7:0],
                           ram_mem[{9'h000, i_ind_sel, 1'b0}][7:0]}
                          + {{8{offset_reg[7]}}, offset_reg};
         end
         else
         begin
            o_ind_addr <= {ram_mem[{9'h000, i_ind_sel, 1'b1}][7:0],
                           ram_mem[{9'h000, i_ind_sel, 1'b0}][7:0]};
         end
         o_table_addr <= {ram_mem[{9'h000, i_ind_sel, 1'b1}],
                          ram_mem[{9'h000, i_ind_sel, 1'b0}][7:0]};
         // Data-space read mux; unmapped SFR and reserved space read zero.
         if (in_ram(i_mem_addr))
         begin
            o_mem_rdata <= ram_mem[i_mem_addr][7:0];
         end
         else
         begin
            case (i_mem_addr)
               `ADDR_WORKING: o_mem_rdata <= working_reg;
               `ADDR_OPHIGH:  o_mem_rdata <= ophigh_reg;
               `ADDR_OFFSET:  o_mem_rdata <= offset_reg;
               `ADDR_PSW:     o_mem_rdata <= {psw_reg[7:1], parity_w};
               `ADDR_SP_LOW:  o_mem_rdata <= sp_reg[7:0];
               `ADDR_SP_HIGH: o_mem_rdata <= sp_reg[15:8];
               default:       o_mem_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // cpu_core_regs_pc_stack

//--- cpu_core_defines.vh
`ifndef CPU_CORE_DEFINES_VH
`define CPU_CORE_DEFINES_VH
// ==========================================================================
// Register map inside the internal data space.
`define ADDR_WORKING    16'hfe00
`define ADDR_OPHIGH     16'hfe01
`define ADDR_OFFSET     16'hfe02
`define ADDR_PSW        16'hfe06
`define ADDR_SP_LOW     16'hfe0a
`define ADDR_SP_HIGH    16'hfe0b
// ==========================================================================
// Memory space limits.
`define RAM_TOP         16'hfdff
`define IND_REG_TOP     16'h007f
`define RAM_DEPTH       65024
// ==========================================================================
// Status word bit positions.
`define PSW_CARRY       7
`define PSW_HALF        6
`define PSW_USER_HI     5
`define PSW_USER_LO     4
`define PSW_TBL_BANK    3
`define PSW_RANGE       2
`define PSW_NINTH       1
`define PSW_PARITY      0
// ==========================================================================
// Reset values and vectors.
`define RST_BYTE        8'h00
`define RST_PC          17'h00000
`define VEC_BASE        17'h00003
`define VEC_STEP_SHIFT  3
`define VEC_LAST        4'h9
// ==========================================================================
// Program counter operation codes.
`define PC_OP_STEP      3'h0
`define PC_OP_BRANCH    3'h1
`define PC_OP_JUMP      3'h2
`define PC_OP_CALL      3'h3
`define PC_OP_RETURN    3'h4
`define PC_OP_INTR      3'h5
`define PC_OP_HOLD      3'h6
`endif

//--- cpu_core_regs_pc_stack_properties.sv
`timescale 1ns/1ps
`include "cpu_core_defines.vh"
// ============================================================
// Port checker for the core register, counter and stack block.
module cpu_core_checker
(
   input wire        i_clk,
   input wire        i_sys_rst,
   input wire [2:0]  i_pc_op,
   input wire [2:0]  i_inst_bytes,
   input wire        i_branch_taken,
   input wire [7:0]  i_branch_disp,
   input wire [16:0] i_jump_target,
   input wire [3:0]  i_intr_index,
   input wire        i_push,
   input wire        i_pop,
   input wire        i_carry_en,
   input wire        i_carry_in,
   input wire [16:0] o_program_counter,
   input wire        o_rom_bank_flag,
   input wire [23:0] o_far_addr,
   input wire [15:0] o_arith_word,
   input wire [15:0] o_stack_pointer,
   input wire [7:0]  o_status_word
);
   reg  [2:0] quiet_reg; // Cycles since the last frame operation.
   wire       calm;      // Frame sequences have settled.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ============================================================
   // Frame operations refuse other requests, so the counter and stack checks judge only calm cycles.
   always @(posedge i_clk)
   begin
      if (i_sys_rst || i_pc_op == `PC_OP_CALL || i_pc_op == `PC_OP_RETURN
          || i_pc_op == `PC_OP_INTR)
         quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7)
         quiet_reg <= quiet_reg + 3'h1;
   end
   assign calm = (quiet_reg > 3'h2);
   // ============================================================
   reset_clear_a: assert property (disable iff (1'b0) i_sys_rst [*3] |->
      o_program_counter == 17'h0 && o_stack_pointer == 16'h0 && o_status_word == 8'h0)
      else $error("outputs not cleared by reset");
   parity_live_a: assert property (o_status_word[0] == ^o_arith_word[7:0])
      else $error("parity flag wrong");
   far_high_a: assert property (o_far_addr[23:16] == o_arith_word[15:8])
      else $error("far address high byte wrong");
   step_adds_a: assert property (calm && i_pc_op == `PC_OP_STEP
      && $past(i_pc_op) == `PC_OP_HOLD |-> ##2 o_program_counter ==
      $past(o_program_counter, 2) + 17'($past(i_inst_bytes, 2)) && $stable(o_rom_bank_flag))
      else $error("step advance wrong");
   branch_adds_a: assert property (calm && i_pc_op == `PC_OP_BRANCH && i_branch_taken
      && $past(i_pc_op) == `PC_OP_HOLD |-> ##2 o_program_counter ==
      $past(o_program_counter, 2) + 17'($past(i_inst_bytes, 2))
      + 17'($signed($past(i_branch_disp, 2))))
      else $error("branch target wrong");
   jump_keeps_a: assert property (calm && i_pc_op == `PC_OP_JUMP
      && $past(i_pc_op) == `PC_OP_HOLD |-> ##2 o_program_counter ==
      $past(i_jump_target, 2) && o_rom_bank_flag == $past(o_rom_bank_flag, 2))
      else $error("jump wrong");
   intr_vector_a: assert property (calm && i_pc_op == `PC_OP_INTR && i_intr_index < 4'ha
      |-> ##4 o_program_counter == 17'h3 + {$past(i_intr_index, 4), 3'h0}
      && !o_rom_bank_flag && o_stack_pointer == $past(o_stack_pointer, 4) + 16'h2)
      else $error("interrupt entry wrong");
   ret_pops_a: assert property (calm && i_pc_op == `PC_OP_RETURN
      |-> ##4 o_stack_pointer == $past(o_stack_pointer, 4) - 16'h2)
      else $error("return pointer wrong");
   push_inc_a: assert property (calm && i_push && !i_pop
      |-> ##2 o_stack_pointer == $past(o_stack_pointer, 2) + 16'h1)
      else $error("push pointer wrong");
   pop_dec_a: assert property (calm && i_pop && !i_push
      |-> ##2 o_stack_pointer == $past(o_stack_pointer, 2) - 16'h1)
      else $error("pop pointer wrong");
   carry_load_a: assert property (i_carry_en |-> ##2 o_status_word[7] == $past(i_carry_in, 2))
      else $error("carry flag wrong");
endmodule // cpu_core_checker

bind cpu_core_regs_pc_stack cpu_core_checker cpu_core_checker_inst
(
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pc_op(i_pc_op), .i_inst_bytes(i_inst_bytes),
   .i_branch_taken(i_branch_taken), .i_branch_disp(i_branch_disp),
   .i_jump_target(i_jump_target), .i_intr_index(i_intr_index), .i_push(i_push),
   .i_pop(i_pop), .i_carry_en(i_carry_en), .i_carry_in(i_carry_in),
   .o_program_counter(o_program_counter), .o_rom_bank_flag(o_rom_bank_flag),
   .o_far_addr(o_far_addr), .o_arith_word(o_arith_word),
   .o_stack_pointer(o_stack_pointer), .o_status_word(o_status_word)
);

//--- tb_cpu_core_regs_pc_stack.sv
`timescale 1ns/1ps
`include "cpu_core_defines.vh"
// ============================================================
// Self-checking bench; every input changes at the falling edge.
module tb_cpu_core_regs_pc_stack;
   reg i_clk, i_sys_rst, i_branch_taken, i_mem_wr, i_mem_rd, i_push, i_pop;
   reg i_alu_wr, i_alu_wr_high, i_alu_wr_ext, i_carry_en, i_carry_in;
   reg i_half_en, i_half_in, i_range_en, i_range_in, i_ind_use_off;
   reg [2:0] i_pc_op, i_inst_bytes;
   reg [7:0] i_branch_disp, i_mem_wdata, i_alu_result, i_alu_high, i_alu_ext;
   reg [16:0] i_jump_target;
   reg [3:0] i_intr_index;
   reg [15:0] i_mem_addr, i_far_low;
   reg [5:0] i_ind_sel;
   wire [16:0] o_program_counter, o_table_addr;
   wire o_rom_bank_flag;
   wire [7:0] o_mem_rdata, o_status_word;
   wire [15:0] o_ind_addr, o_arith_word, o_stack_pointer;
   wire [23:0] o_far_addr;
   integer n_mismatch, tests_run, i;
   reg [15:0] adr [0:4]; // Register addresses under test.
   reg [7:0] val [0:4];  // Values written to them.

   cpu_core_regs_pc_stack cpu_core_regs_pc_stack_inst (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pc_op(i_pc_op), .i_inst_bytes(i_inst_bytes),
      .i_branch_taken(i_branch_taken), .i_branch_disp(i_branch_disp),
      .i_jump_target(i_jump_target), .i_intr_index(i_intr_index), .i_mem_wr(i_mem_wr),
      .i_mem_rd(i_mem_rd), .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata),
      .i_push(i_push), .i_pop(i_pop), .i_alu_wr(i_alu_wr), .i_alu_result(i_alu_result),
      .i_alu_wr_high(i_alu_wr_high), .i_alu_high(i_alu_high), .i_alu_wr_ext(i_alu_wr_ext),
      .i_alu_ext(i_alu_ext), .i_carry_en(i_carry_en), .i_carry_in(i_carry_in),
      .i_half_en(i_half_en), .i_half_in(i_half_in), .i_range_en(i_range_en),
      .i_range_in(i_range_in), .i_ind_sel(i_ind_sel), .i_ind_use_off(i_ind_use_off),
      .i_far_low(i_far_low), .o_program_counter(o_program_counter),
      .o_rom_bank_flag(o_rom_bank_flag), .o_mem_rdata(o_mem_rdata), .o_ind_addr(o_ind_addr),
      .o_table_addr(o_table_addr), .o_far_addr(o_far_addr), .o_arith_word(o_arith_word),
      .o_stack_pointer(o_stack_pointer), .o_status_word(o_status_word));

   always #50 i_clk = ~i_clk;

   // Compare one result; values are widened so one task serves all widths.
   task chk(input [23:0] got, input [23:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge i_clk);
   endtask
   // Data-space write, one strobe cycle, then settle.
   task wr(input [15:0] a, input [7:0] d);
      begin
         i_mem_wr = 1'b1; i_mem_addr = a; i_mem_wdata = d; cyc(1);
         i_mem_wr = 1'b0; cyc(3);
      end
   endtask
   // Data-space read compared against an expected byte.
   task rd(input [15:0] a, input [7:0] e);
      begin
         i_mem_rd = 1'b1; i_mem_addr = a; cyc(1);
         i_mem_rd = 1'b0; cyc(2); chk(o_mem_rdata, e);
      end
   endtask
   // One counter request; long hold covers the refused frame cycles.
   task pcop(input [2:0] op);
      begin
         i_pc_op = op; cyc(1); i_pc_op = `PC_OP_HOLD; cyc(5);
      end
   endtask
   task wrap_up;
      begin
         $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
         if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // ============================================================
   // Main sequence.
   initial
   begin
      {i_clk, i_branch_taken, i_mem_wr, i_mem_rd, i_push, i_pop, i_alu_wr} = 7'h0;
      {i_alu_wr_high, i_alu_wr_ext, i_carry_en, i_carry_in, i_half_en} = 5'h0;
      {i_half_in, i_range_en, i_range_in, i_ind_use_off} = 4'h0;
      i_sys_rst = 1'b1; i_pc_op = `PC_OP_HOLD; i_inst_bytes = 3'h0;
      {i_branch_disp, i_mem_wdata, i_alu_result, i_alu_high, i_alu_ext} = 40'h0;
      i_jump_target = 17'h0; i_intr_index = 4'h0; i_mem_addr = 16'h0;
      i_far_low = 16'h1357; i_ind_sel = 6'h0;
      n_mismatch = 0; tests_run = 0;
      adr[0] = `ADDR_WORKING; adr[1] = `ADDR_OPHIGH; adr[2] = `ADDR_OFFSET;
      adr[3] = `ADDR_SP_LOW; adr[4] = `ADDR_SP_HIGH;
      val[0] = 8'hb5; val[1] = 8'h9c; val[2] = 8'hfe; val[3] = 8'h02; val[4] = 8'h01;
      cyc(20); i_sys_rst = 1'b0; cyc(2);
      // Reset values, then write and read back each register.
      for (i = 0; i < 5; i = i + 1) rd(adr[i], 8'h00);
      rd(`ADDR_PSW, 8'h00);
      for (i = 0; i < 5; i = i + 1) wr(adr[i], val[i]);
      for (i = 0; i < 5; i = i + 1) rd(adr[i], val[i]);
      chk(o_arith_word, 24'h9cb5);
      chk(o_far_addr, 24'h9c1357);
      chk(o_stack_pointer, 24'h0102);
      // Parity is odd for the working value; bit 0 of the write is ignored.
      wr(`ADDR_PSW, 8'h3a);
      rd(`ADDR_PSW, 8'h3b);
      // Indirect register 1 holds 0x123 with the ninth bit set.
      wr(16'h0002, 8'h23); wr(16'h0003, 8'h01); i_ind_sel = 6'h01; cyc(3);
      chk(o_ind_addr, 24'h0123);
      chk(o_table_addr, 24'h10123);
      i_ind_use_off = 1'b1; cyc(3);
      chk(o_ind_addr, 24'h0121);
      // Return through a prepared frame switches to bank 1.
      wr(16'h0101, 8'h34); wr(16'h0102, 8'h12);
      pcop(`PC_OP_RETURN);
      chk({o_rom_bank_flag, o_program_counter}, 24'h31234);
      chk(o_stack_pointer, 24'h0100);
      i_inst_bytes = 3'h3; pcop(`PC_OP_STEP);
      chk({o_rom_bank_flag, o_program_counter}, 24'h31237);
      i_inst_bytes = 3'h2; i_branch_taken = 1'b1; i_branch_disp = 8'h80;
      pcop(`PC_OP_BRANCH);
      chk({o_rom_bank_flag, o_program_counter}, 24'h311b9);
      i_jump_target = 17'h00abc; pcop(`PC_OP_JUMP);
      chk({o_rom_bank_flag, o_program_counter}, 24'h20abc);
      // The call frame carries the counter held before the call.
      i_jump_target = 17'h1f000; pcop(`PC_OP_CALL);
      chk({o_rom_bank_flag, o_program_counter}, 24'h3f000);
      chk(o_stack_pointer, 24'h0102);
      rd(16'h0101, 8'hbc);
      rd(16'h0102, 8'h0a);
      // Every interrupt vector clears the bank and pushes a frame.
      for (i = 0; i < 10; i = i + 1)
      begin
         i_intr_index = i[3:0]; pcop(`PC_OP_INTR);
         chk({o_rom_bank_flag, o_program_counter}, 24'h3 + 8 * i);
         chk(o_stack_pointer, 24'h0104 + 2 * i);
      end
      i_mem_wdata = 8'h5a; i_push = 1'b1; cyc(1); i_push = 1'b0; cyc(3);
      chk(o_stack_pointer, 24'h0117);
      rd(16'h0117, 8'h5a);
      i_pop = 1'b1; cyc(1); i_pop = 1'b0; cyc(3);
      chk(o_stack_pointer, 24'h0116);
      // Out-of-range interrupt indices fall back to the last vector.
      i_intr_index = 4'hf; pcop(`PC_OP_INTR);
      chk({o_rom_bank_flag, o_program_counter}, 24'h4b);
      chk(o_stack_pointer, 24'h0118);
      // Arithmetic results load the pair, the offset and the flags.
      // The ninth-bit flag is clear here, left so by the frame read and the pop.
      for (i = 0; i < 2; i = i + 1)
      begin
         {i_alu_wr, i_alu_wr_high, i_alu_wr_ext, i_carry_en, i_half_en, i_range_en} = 6'h3f;
         i_alu_result = i ? 8'h03 : 8'h07; i_alu_high = 8'h44; i_alu_ext = 8'h66;
         {i_carry_in, i_half_in, i_range_in} = i ? 3'b010 : 3'b101; cyc(1);
         {i_alu_wr, i_alu_wr_high, i_alu_wr_ext, i_carry_en, i_half_en, i_range_en} = 6'h0;
         cyc(3);
         chk(o_status_word, i ? 24'h78 : 24'hbd);
         chk(o_arith_word, i ? 24'h4403 : 24'h4407);
      end
      rd(`ADDR_OFFSET, 8'h66);
      // A second reset in mid-run clears the counter and registers.
      i_sys_rst = 1'b1; cyc(3); i_sys_rst = 1'b0; cyc(2);
      chk({o_rom_bank_flag, o_program_counter}, 24'h0);
      chk({o_stack_pointer, o_status_word}, 24'h0);
      wrap_up;
   end
endmodule // tb_cpu_core_regs_pc_stack
